//--- inc/bmcc_defs.svh
`ifndef BMCC_DEFS_SVH
`define BMCC_DEFS_SVH

// Serial word layout, shifted msb first
`define BMCC_WORD_BITS   11
`define BMCC_START_BIT   10
`define BMCC_DIR_BIT     9
`define BMCC_TQ_HI       8
`define BMCC_TQ_LO       1
`define BMCC_KIND_BIT    0
`define BMCC_OP_HI       2
`define BMCC_OP_LO       1
`define BMCC_LAST_BIT    4'd10
`define BMCC_FULL_WORD   4'd11

// Timing
`define BMCC_CLK_HZ      100000000
`define BMCC_CMD_RATE_HZ 250
`define BMCC_REFRESH_CYC (`BMCC_CLK_HZ / `BMCC_CMD_RATE_HZ)
`define BMCC_SCK_HALF    8'd8
`define BMCC_SAW_MAX     8'hff

// Host register map, byte addresses
`define BMCC_WB_CMD      8'h00
`define BMCC_WB_STAT     8'h04
`define BMCC_WB_CTRL     8'h08
`define BMCC_WB_OFS_TU   8'h0c
`define BMCC_WB_OFS_SP   8'h10

// Host command register fields
`define BMCC_CMD_TQ_HI   7
`define BMCC_CMD_DIR     8
`define BMCC_CMD_OP_HI   10
`define BMCC_CMD_OP_LO   9
`define BMCC_CMD_TG_HI   13
`define BMCC_CMD_TG_LO   12
`define BMCC_TGT_BLOWER  2'd2

`endif

//--- inc/bmcc_link_if.sv
`timescale 1ns/1ps

// Shared serial link from the motion host to three motor ends
interface bmcc_link_if;
  logic sck;
  logic mosi;
  logic takeup_select_n;
  logic supply_select_n;
  logic blower_select_n;

  modport host (
    output sck,
    output mosi,
    output takeup_select_n,
    output supply_select_n,
    output blower_select_n
  );

  modport dev (
    input sck,
    input mosi,
    input takeup_select_n,
    input supply_select_n,
    input blower_select_n
  );
endinterface

//--- inc/bmcc_pkg.sv
`include "bmcc_defs.svh"

package bmcc_pkg;

  // Control word opcodes
  typedef enum logic [1:0] {
    BMCC_OP_RUN     = 2'b00,
    BMCC_OP_BRAKE   = 2'b01,
    BMCC_OP_LOCK    = 2'b10,
    BMCC_OP_DISABLE = 2'b11
  } bmcc_op_e;

  // Drive modes of the motor end
  typedef enum logic [1:0] {
    BMCC_M_OFF   = 2'b00,
    BMCC_M_RUN   = 2'b01,
    BMCC_M_BRAKE = 2'b10,
    BMCC_M_LOCK  = 2'b11
  } bmcc_mode_e;

  // Host link sequencer states
  typedef enum logic [1:0] {
    BMCC_H_IDLE  = 2'b00,
    BMCC_H_SHIFT = 2'b01,
    BMCC_H_GAP   = 2'b10
  } bmcc_hst_e;

  typedef logic [`BMCC_WORD_BITS-1:0] bmcc_word_t;

  // Motor end state
  typedef struct packed {
    logic       sck_s1, sck_s2, sck_s3;
    logic       sel_s1, sel_s2, sel_s3;
    logic       mosi_s1, mosi_s2;
    logic [2:0] hall_s1, hall_s2;
    logic       over_s1, over_s2;
    logic       sync_s1, sync_s2, sync_s3;
    bmcc_word_t shift;
    logic [3:0] bits;
    logic       hold_dir;
    logic [7:0] hold_tq;
    logic       act_dir;
    logic [7:0] act_tq;
    bmcc_mode_e mode;
    logic [2:0] lock_step;
    logic [7:0] saw;
    logic       on_latch;
    logic [2:0] hi;
    logic [2:0] lo;
    logic [8:0] iref;
    logic       sync_o;
  } bmcc_dev_s;

  // Host end state
  typedef struct packed {
    bmcc_hst_e   st;
    logic [7:0]  div;
    logic [18:0] rcnt;
    logic        sck;
    logic        mosi;
    logic [2:0]  sel_n;
    logic [2:0]  sel_hold;
    bmcc_word_t  shift;
    bmcc_word_t  w1;
    logic        second;
    logic [3:0]  bitc;
    logic        ack;
    logic [31:0] dat;
    logic        tens;
    logic        due;
    logic [7:0]  ofs_tu;
    logic [7:0]  ofs_sp;
  } bmcc_host_s;

endpackage

//--- logic/bmcc_host.sv
`timescale 1ns/1ps
`include "bmcc_defs.svh"

module bmcc_host #(
  parameter int REFRESH_CYC = `BMCC_REFRESH_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Serial link
  bmcc_link_if.host        lnk
);
  import bmcc_pkg::*;

  bmcc_host_s r_reg;
  bmcc_host_s r_next;
  logic       take;
  logic       wr;
  logic       half;
  logic       tick;
  logic [7:0] tq_raw;
  logic [7:0] ofs;
  logic [7:0] tq_fix;
  logic [1:0] tgt;

  assign take   = wb_cyc_i & wb_stb_i & ~r_reg.ack;
  // Writes land at the edge that sees ack high
  assign wr     = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & r_reg.ack;
  assign half   = (r_reg.div == `BMCC_SCK_HALF - 8'd1);
  assign tick   = (r_reg.rcnt == 19'(REFRESH_CYC - 1));
  assign tq_raw = wb_dat_i[`BMCC_CMD_TQ_HI:0];
  assign tgt    = wb_dat_i[`BMCC_CMD_TG_HI:`BMCC_CMD_TG_LO];

  // Reel offset correction, blower left as is
  always_comb
  begin
    unique case (tgt)
      2'd0:    ofs = r_reg.ofs_tu;
      2'd1:    ofs = r_reg.ofs_sp;
      default: ofs = 8'h00;
    endcase
    tq_fix = (tq_raw > ofs) ? tq_raw - ofs : 8'h00;
  end

  // Next state
  always_comb
  begin
    r_next     = r_reg;
    r_next.ack = take;
    r_next.div = half ? 8'h00 : r_reg.div + 8'h01;
    r_next.rcnt = tick ? 19'h0 : r_reg.rcnt + 19'h1;

    // Register access
    if (take)
    begin
      unique case (wb_adr_i)
        `BMCC_WB_STAT:   r_next.dat = {30'h0, r_reg.due,
                                       r_reg.st != BMCC_H_IDLE};
        `BMCC_WB_CTRL:   r_next.dat = {31'h0, r_reg.tens};
        `BMCC_WB_OFS_TU: r_next.dat = {24'h0, r_reg.ofs_tu};
        `BMCC_WB_OFS_SP: r_next.dat = {24'h0, r_reg.ofs_sp};
        default:         r_next.dat = 32'h0;
      endcase
    end
    if (wr)
    begin
      unique case (wb_adr_i)
        `BMCC_WB_CTRL:   r_next.tens   = wb_dat_i[0];
        `BMCC_WB_OFS_TU: r_next.ofs_tu = wb_dat_i[7:0];
        `BMCC_WB_OFS_SP: r_next.ofs_sp = wb_dat_i[7:0];
        default:         r_next.tens   = r_reg.tens;
      endcase
    end

    // Command write starts a word pair when idle
    if (wr && wb_adr_i == `BMCC_WB_CMD)
    begin
      r_next.due = 1'b0;
      if (r_reg.st == BMCC_H_IDLE && tgt <= `BMCC_TGT_BLOWER)
      begin
        r_next.shift = {1'b1, wb_dat_i[`BMCC_CMD_DIR], tq_fix, 1'b0};
        r_next.w1    = {1'b1, 7'h00,
                        wb_dat_i[`BMCC_CMD_OP_HI:`BMCC_CMD_OP_LO], 1'b1};
        r_next.sel_hold = ~(3'b001 << tgt);
        r_next.sel_n    = ~(3'b001 << tgt);
        r_next.mosi     = 1'b1;
        r_next.second   = 1'b0;
        r_next.bitc     = 4'h0;
        r_next.div      = 8'h00;
        r_next.st       = BMCC_H_SHIFT;
      end
    end

    // Refresh request while tensioned; set wins over clear
    if (tick && r_reg.tens)
    begin
      r_next.due = 1'b1;
    end

    // Link sequencer, one bit per clock pulse
    unique case (r_reg.st)
      BMCC_H_IDLE:
      begin
        r_next.sck = 1'b0;
      end
      BMCC_H_SHIFT:
      begin
        if (half && !r_reg.sck)
        begin
          r_next.sck = 1'b1;
        end
        else if (half)
        begin
          r_next.sck  = 1'b0;
          r_next.bitc = r_reg.bitc + 4'h1;
          if (r_reg.bitc == `BMCC_LAST_BIT)
          begin
            r_next.sel_n = 3'b111;
            r_next.st    = BMCC_H_GAP;
          end
          else
          begin
            r_next.shift = {r_reg.shift[`BMCC_WORD_BITS-2:0], 1'b0};
            r_next.mosi  = r_reg.shift[`BMCC_WORD_BITS-2];
          end
        end
      end
      BMCC_H_GAP:
      begin
        if (half && !r_reg.second)
        begin
          r_next.shift  = r_reg.w1;
          r_next.mosi   = r_reg.w1[`BMCC_START_BIT];
          r_next.sel_n  = r_reg.sel_hold;
          r_next.second = 1'b1;
          r_next.bitc   = 4'h0;
          r_next.st     = BMCC_H_SHIFT;
        end
        else if (half)
        begin
          r_next.st = BMCC_H_IDLE;
        end
      end
      default: r_next.st = BMCC_H_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r_reg          <= '0;
      r_reg.st       <= BMCC_H_IDLE;
      r_reg.sel_n    <= 3'b111;
      r_reg.sel_hold <= 3'b111;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from state
  assign wb_ack_o            = r_reg.ack;
  assign wb_dat_o            = r_reg.dat;
  assign lnk.sck             = r_reg.sck;
  assign lnk.mosi            = r_reg.mosi;
  assign lnk.takeup_select_n = r_reg.sel_n[0];
  assign lnk.supply_select_n = r_reg.sel_n[1];
  assign lnk.blower_select_n = r_reg.sel_n[2];

endmodule // bmcc_host

//--- logic/bmcc_motor.sv
// How it works
// - host shifts one bit per clock pulse
// - one select low; only selected end listens
// - host flags a refresh as due 250 times per second while tensioned
// - torque word: start, direction, eight torque bits
// - torque word loads holding register by itself
// - run applies held direction and torque
// - brake shorts windings through low switches
// - lock holds stopped rotor at one step
// - disable turns every switch off
// - Hall inputs pick the energised phase pair
// - six steps per electrical cycle
// - one high and one low terminal driven
// - on-pulse width follows commanded torque
// - switch mode, current trip ends pulse
// - nine-bit current reference from command
// - master sawtooth restarts the other ends
// - host subtracts reel offsets, not blower
// - commands travel as pairs of 11-bit words
// - three complementary switch pairs out
`timescale 1ns/1ps
`include "bmcc_defs.svh"

module bmcc_motor #(
  parameter int SEL_IDX     = 0,
  parameter bit SYNC_MASTER = 1'b0
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Serial link
  bmcc_link_if.dev                lnk,
  // Motor sensing
  input  wire logic [2:0]         hall_i,
  input  wire logic               sense_over_i,
  // Sawtooth sync
  input  wire logic               saw_sync_i,
  output logic                    saw_sync_o,
  // Power switch drive
  output logic [2:0]              drive_hi_o,
  output logic [2:0]              drive_lo_o,
  // Current reference and status
  output logic [8:0]              iref_o,
  output bmcc_pkg::bmcc_mode_e    mode_o
);
  import bmcc_pkg::*;

  bmcc_dev_s r_reg;
  bmcc_dev_s r_next;
  logic      sel_pin;
  logic      sck_rise;
  logic      sel_fall;
  logic      sel_rise;
  logic      pwm_on;
  logic [2:0] step_now;
  logic [5:0] drv_run;
  logic [5:0] drv_lock;

  // Hall code to commutation step, 7 marks an illegal code
  function automatic logic [2:0] bmcc_step(input logic [2:0] h);
    logic [2:0] s;
    unique case (h)
      3'b001:  s = 3'h0;
      3'b011:  s = 3'h1;
      3'b010:  s = 3'h2;
      3'b110:  s = 3'h3;
      3'b100:  s = 3'h4;
      3'b101:  s = 3'h5;
      default: s = 3'h7;
    endcase
    return s;
  endfunction

  // Step to {high side, low side}; reverse swaps the pair
  function automatic logic [5:0] bmcc_drive(input logic [2:0] s,
                                            input logic       d);
    logic [2:0] a;
    logic [2:0] b;
    unique case (s)
      3'h0:    begin a = 3'b001; b = 3'b010; end
      3'h1:    begin a = 3'b001; b = 3'b100; end
      3'h2:    begin a = 3'b010; b = 3'b100; end
      3'h3:    begin a = 3'b010; b = 3'b001; end
      3'h4:    begin a = 3'b100; b = 3'b001; end
      3'h5:    begin a = 3'b100; b = 3'b010; end
      default: begin a = 3'b000; b = 3'b000; end
    endcase
    return d ? {b, a} : {a, b};
  endfunction

  // Pick this end's select line
  always_comb
  begin
    unique case (SEL_IDX)
      0:       sel_pin = lnk.takeup_select_n;
      1:       sel_pin = lnk.supply_select_n;
      default: sel_pin = lnk.blower_select_n;
    endcase
  end

  // Edges and drive patterns from synchronised inputs
  assign sck_rise = r_reg.sck_s2 & ~r_reg.sck_s3;
  assign sel_fall = ~r_reg.sel_s2 & r_reg.sel_s3;
  assign sel_rise = r_reg.sel_s2 & ~r_reg.sel_s3;
  assign step_now = bmcc_step(r_reg.hall_s2);
  assign pwm_on   = r_reg.on_latch & (r_reg.saw < r_reg.act_tq);
  assign drv_run  = bmcc_drive(step_now, r_reg.act_dir);
  assign drv_lock = bmcc_drive(r_reg.lock_step, r_reg.act_dir);

  // Next state
  always_comb
  begin
    r_next = r_reg;
    // Two-flop synchronisers for every pin
    r_next.sck_s1  = lnk.sck;
    r_next.sck_s2  = r_reg.sck_s1;
    r_next.sck_s3  = r_reg.sck_s2;
    r_next.sel_s1  = sel_pin;
    r_next.sel_s2  = r_reg.sel_s1;
    r_next.sel_s3  = r_reg.sel_s2;
    r_next.mosi_s1 = lnk.mosi;
    r_next.mosi_s2 = r_reg.mosi_s1;
    r_next.hall_s1 = hall_i;
    r_next.hall_s2 = r_reg.hall_s1;
    r_next.over_s1 = sense_over_i;
    r_next.over_s2 = r_reg.over_s1;
    r_next.sync_s1 = saw_sync_i;
    r_next.sync_s2 = r_reg.sync_s1;
    r_next.sync_s3 = r_reg.sync_s2;

    // Word receiver, listens only while selected
    if (sel_fall)
    begin
      r_next.bits = 4'h0;
    end
    else if (!r_reg.sel_s2 && sck_rise)
    begin
      r_next.shift = {r_reg.shift[`BMCC_WORD_BITS-2:0], r_reg.mosi_s2};
      if (r_reg.bits != 4'hf)
      begin
        r_next.bits = r_reg.bits + 4'h1;
      end
    end

    // Decode a complete word when select is released
    if (sel_rise && r_reg.bits == `BMCC_FULL_WORD
        && r_reg.shift[`BMCC_START_BIT])
    begin
      if (!r_reg.shift[`BMCC_KIND_BIT])
      begin
        r_next.hold_dir = r_reg.shift[`BMCC_DIR_BIT];
        r_next.hold_tq  = r_reg.shift[`BMCC_TQ_HI:`BMCC_TQ_LO];
      end
      else
      begin
        unique case (bmcc_op_e'(r_reg.shift[`BMCC_OP_HI:`BMCC_OP_LO]))
          BMCC_OP_RUN:
          begin
            r_next.mode    = BMCC_M_RUN;
            r_next.act_dir = r_reg.hold_dir;
            r_next.act_tq  = r_reg.hold_tq;
          end
          BMCC_OP_BRAKE:   r_next.mode = BMCC_M_BRAKE;
          BMCC_OP_LOCK:
          begin
            r_next.mode      = BMCC_M_LOCK;
            r_next.lock_step = (step_now == 3'h7) ? 3'h0 : step_now;
          end
          BMCC_OP_DISABLE: r_next.mode = BMCC_M_OFF;
        endcase
      end
    end

    // Sawtooth; a slave restarts on the master's wrap
    r_next.saw = r_reg.saw + 8'h01;
    if (!SYNC_MASTER && r_reg.sync_s2 && !r_reg.sync_s3)
    begin
      r_next.saw = 8'h00;
    end
    r_next.sync_o = SYNC_MASTER && (r_reg.saw == `BMCC_SAW_MAX);

    // Pulse starts at wrap, current trip ends it
    if (r_reg.saw == 8'h00)
    begin
      r_next.on_latch = 1'b1;
    end
    if (r_reg.over_s2)
    begin
      r_next.on_latch = 1'b0;
    end

    // Switch drive per mode
    unique case (r_reg.mode)
      BMCC_M_OFF:
      begin
        r_next.hi = 3'b000;
        r_next.lo = 3'b000;
      end
      BMCC_M_RUN:
      begin
        {r_next.hi, r_next.lo} = pwm_on ? drv_run : 6'h00;
      end
      BMCC_M_BRAKE:
      begin
        r_next.hi = 3'b000;
        r_next.lo = 3'b111;
      end
      BMCC_M_LOCK:
      begin
        {r_next.hi, r_next.lo} = pwm_on ? drv_lock : 6'h00;
      end
    endcase

    // Nine-bit signed current reference
    if (r_reg.mode == BMCC_M_RUN || r_reg.mode == BMCC_M_LOCK)
    begin
      r_next.iref = {r_reg.act_dir, r_reg.act_tq};
    end
    else
    begin
      r_next.iref = 9'h000;
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r_reg       <= '0;
      r_reg.mode  <= BMCC_M_OFF;
      r_reg.sck_s1 <= 1'b0;
      r_reg.sel_s1 <= 1'b1;
      r_reg.sel_s2 <= 1'b1;
      r_reg.sel_s3 <= 1'b1;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from state
  assign drive_hi_o = r_reg.hi;
  assign drive_lo_o = r_reg.lo;
  assign iref_o     = r_reg.iref;
  assign mode_o     = r_reg.mode;
  assign saw_sync_o = r_reg.sync_o;

endmodule // bmcc_motor

//--- sim/bmcc_checker.sv
`timescale 1ns/1ps

module bmcc_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link wires
  input wire logic sck,
  input wire logic mosi,
  input wire logic takeup_select_n,
  input wire logic supply_select_n,
  input wire logic blower_select_n
);
  logic [2:0] sel_n;
  logic       idle;
  logic [3:0] rises;

  // Select group and idle flag
  assign sel_n = {blower_select_n, supply_select_n, takeup_select_n};
  assign idle  = &sel_n;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Clock rises counted within one word
  always_ff @(posedge clk_i)
    if (rst_i || idle)
      rises <= 4'h0;
    else if ($rose(sck))
      rises <= rises + 4'h1;

  // Eight low cycles, then first rise
  sequence s_open;
    !sck[*8] ##1 sck;
  endsequence

  // Eight high cycles, then fall
  sequence s_high;
    sck[*8] ##1 !sck;
  endsequence

  AST_ONE_SELECT: assert property ($onehot0(~sel_n))
    else $error("more than one select low");
  AST_SCK_IDLE: assert property (idle |-> !sck)
    else $error("serial clock moves while idle");
  AST_SCK_PULSE: assert property ($rose(sck) |-> s_high)
    else $error("serial clock high time off");
  AST_WORD_OPEN: assert property ($fell(idle) |-> s_open)
    else $error("first clock rise misplaced");
  AST_START_BIT: assert property ($fell(idle) |-> mosi)
    else $error("word does not open with a one");
  AST_MOSI_HOLD: assert property (sck |-> $stable(mosi))
    else $error("data moved while clock high");
  AST_SEL_EDGE: assert property ($changed(sel_n) |-> !sck)
    else $error("select moved while clock high");
  AST_ELEVEN: assert property ($rose(idle) |-> rises == 4'd11)
    else $error("word length is not eleven bits");
  AST_GAP: assert property ($rose(idle) |-> idle[*8])
    else $error("gap between words too short");
endmodule // bmcc_checker

//--- sim/tb_brushless_motor_command_commutation.sv
`timescale 1ns/1ps

module tb_brushless_motor_command_commutation;
  import bmcc_pkg::*;
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             wb_cyc = 1'b0;
  logic             wb_stb = 1'b0;
  logic             wb_we = 1'b0;
  logic [3:0]       wb_sel = 4'h0;
  logic [7:0]       wb_adr = 8'h00;
  logic [31:0]      wb_wdat = 32'h0;
  logic [31:0]      wb_rdat;
  logic [31:0]      rd;
  logic             wb_ack;
  logic [2:0][2:0]  hall = '0;
  logic [2:0]       over = '0;
  wire  [2:0]       syncs;
  wire  [2:0][2:0]  hi;
  wire  [2:0][2:0]  lo;
  logic [2:0][2:0]  hacc, lacc;
  wire  [2:0][8:0]  iref;
  wire  [1:0]       mode [3];
  logic [2:0]       hc [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  logic [2:0]       eh [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
  logic [2:0]       el [6] = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2};
  int               n_mismatch = 0;
  int               total_checks = 0;
  int               npls;
  bmcc_link_if      lnk ();

  // Clock
  always #5 clk_i = ~clk_i;

  bmcc_host #(.REFRESH_CYC(500)) i_bmcc_host (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .wb_cyc_i (wb_cyc),
    .wb_stb_i (wb_stb),
    .wb_we_i  (wb_we),
    .wb_adr_i (wb_adr),
    .wb_dat_i (wb_wdat),
    .wb_sel_i (wb_sel),
    .wb_dat_o (wb_rdat),
    .wb_ack_o (wb_ack),
    .lnk      (lnk)
  );

  // Three motor ends, first one masters the sawtooth
  for (genvar g = 0; g < 3; g++)
  begin : g_mot
    bmcc_motor #(.SEL_IDX(g), .SYNC_MASTER(g == 0)) i_bmcc_motor (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .lnk          (lnk),
      .hall_i       (hall[g]),
      .sense_over_i (over[g]),
      .saw_sync_i   (syncs[0]),
      .saw_sync_o   (syncs[g]),
      .drive_hi_o   (hi[g]),
      .drive_lo_o   (lo[g]),
      .iref_o       (iref[g]),
      .mode_o       (mode[g])
    );
  end

  bmcc_checker i_bmcc_checker (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .sck             (lnk.sck),
    .mosi            (lnk.mosi),
    .takeup_select_n (lnk.takeup_select_n),
    .supply_select_n (lnk.supply_select_n),
    .blower_select_n (lnk.blower_select_n)
  );

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask

  // One classic bus cycle; read data lands in rd
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_sel <= 4'h1;
    wb_adr <= a;
    wb_wdat <= d;
    i = 0;
    do
    begin
      @(posedge clk_i);
      i++;
    end while (wb_ack !== 1'b1 && i < 50);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (i >= 50)
    begin
      n_mismatch++;
      test_done();
    end
  endtask

  // Command write, wait until link idle and motor settled
  task automatic cmd(input logic [1:0] tg, input logic [1:0] op,
                     input logic dir, input logic [7:0] tq);
    int i;
    wb(1'b1, 8'h00, {18'h0, tg, 1'b0, op, dir, tq});
    i = 0;
    do
    begin
      wb(1'b0, 8'h04, 32'h0);
      i++;
    end while (rd[0] !== 1'b0 && i < 400);
    if (i >= 400)
    begin
      n_mismatch++;
      test_done();
    end
    repeat (10) @(posedge clk_i);
  endtask

  // Gather every switch seen on over a few sawtooth periods
  task automatic acc();
    repeat (8) @(posedge clk_i);
    hacc = '0;
    lacc = '0;
    repeat (600)
    begin
      @(posedge clk_i);
      hacc = hacc | hi;
      lacc = lacc | lo;
    end
  endtask

  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int g = 0; g < 3; g++)
    begin
      chk(mode[g], BMCC_M_OFF);
      chk({hi[g], lo[g], iref[g]}, 32'h0);
    end
    wb(1'b1, 8'h0c, 32'h10);
    wb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h10);
    wb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 8'h08, 32'h1);
    repeat (600) @(posedge clk_i);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd[1], 1'b1);
    cmd(2'd0, BMCC_OP_RUN, 1'b0, 8'h90);
    chk(iref[0], 9'h080);
    chk(mode[0], BMCC_M_RUN);
    chk(mode[1], BMCC_M_OFF);
    for (int k = 0; k < 6; k++)
    begin
      hall[0] <= hc[k];
      acc();
      chk(hacc[0], eh[k]);
      chk(lacc[0], el[k]);
    end
    hall[0] <= 3'h0;
    acc();
    chk({hacc[0], lacc[0]}, 6'h0);
    hall[0] <= 3'h1;
    cmd(2'd0, BMCC_OP_RUN, 1'b1, 8'h90);
    acc();
    chk({hacc[0], lacc[0]}, 6'h11);
    cmd(2'd0, BMCC_OP_RUN, 1'b0, 8'h08);
    chk(iref[0], 9'h000);
    acc();
    chk({hacc[0], lacc[0]}, 6'h0);
    cmd(2'd0, BMCC_OP_RUN, 1'b0, 8'hf0);
    over[0] <= 1'b1;
    acc();
    chk({hacc[0], lacc[0]}, 6'h0);
    over[0] <= 1'b0;
    acc();
    chk({hacc[0], lacc[0]}, 6'h0a);
    cmd(2'd0, BMCC_OP_BRAKE, 1'b0, 8'h00);
    chk(mode[0], BMCC_M_BRAKE);
    acc();
    chk({hacc[0], lacc[0]}, 6'h07);
    cmd(2'd0, BMCC_OP_LOCK, 1'b0, 8'h00);
    chk(mode[0], BMCC_M_LOCK);
    hall[0] <= 3'h3;
    acc();
    chk({hacc[0], lacc[0]}, 6'h0a);
    cmd(2'd0, BMCC_OP_DISABLE, 1'b0, 8'h00);
    chk(mode[0], BMCC_M_OFF);
    acc();
    chk({hacc[0], lacc[0], iref[0]}, 32'h0);
    cmd(2'd2, BMCC_OP_RUN, 1'b1, 8'h33);
    chk(iref[2], 9'h133);
    chk(mode[0], BMCC_M_OFF);
    cmd(2'd3, BMCC_OP_BRAKE, 1'b0, 8'h00);
    chk(mode[2], BMCC_M_RUN);
    npls = 0;
    repeat (512)
    begin
      @(posedge clk_i);
      npls += syncs[0];
      chk(syncs[2:1], 2'b00);
    end
    chk(npls, 2);
    test_done();
  end
endmodule // tb_brushless_motor_command_commutation
